// [epp_cycle_pkg.sv]
// Shared constants and types for the enhanced parallel port cycle engine
package epp_cycle_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_DATA      = 6'h00;
  localparam logic [5:0] IDX_STATUS    = 6'h01;
  localparam logic [5:0] IDX_CONTROL   = 6'h02;
  localparam logic [5:0] IDX_EPP_ADDR  = 6'h03;
  localparam logic [5:0] IDX_EPP_DATA0 = 6'h04;
  localparam logic [5:0] IDX_EPP_DATA3 = 6'h07;
  localparam logic [5:0] IDX_MODE      = 6'h08;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int unsigned ST_TIMEOUT_BIT = 0;

  // ---------------------------------------------------------------
  // Control register fields and reset value
  // ---------------------------------------------------------------
  localparam int unsigned CTL_STROBE_BIT = 0;
  localparam int unsigned CTL_AUTOFD_BIT = 1;
  localparam int unsigned CTL_NINIT_BIT  = 2;
  localparam int unsigned CTL_SELIN_BIT  = 3;
  localparam int unsigned CTL_DIR_BIT    = 5;
  localparam logic [5:0]  CTL_RESET      = 6'h00;

  // ---------------------------------------------------------------
  // Mode register fields, writable mask and reset value
  // ---------------------------------------------------------------
  localparam int unsigned MODE_EPP_EN_BIT = 0;
  localparam int unsigned MODE_V17_BIT    = 1;
  localparam int unsigned MODE_TSEL_BIT   = 4;
  localparam logic [7:0]  MODE_MASK       = 8'h13;
  localparam logic [7:0]  MODE_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // Reset values of data registers
  // ---------------------------------------------------------------
  localparam logic [7:0]  BYTE_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned WD_TIMEOUT_US  = 10;
  localparam int unsigned WD_CYCLES      = (WD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned WD_W           = 8;

  // ---------------------------------------------------------------
  // Cycle sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE_WAIT,
    ST_SETUP,
    ST_STROBE,
    ST_DONE
  } epp_state_type;

endpackage

// [epp_pin_sync.sv]
// Two-stage synchroniser for the parallel port input pins
`timescale 1ns/1ps
module epp_pin_sync #(
  parameter int unsigned WIDTH = 15
) (
  // Clock and reset
  input  wire logic             SYS_CLK,
  input  wire logic             RESETN,
  // Pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] PIN_IN,
  output logic      [WIDTH-1:0] PIN_SYNC
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  // ---------------------------------------------------------------
  // Width check
  // ---------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("epp_pin_sync needs at least one bit");
  end

  // ---------------------------------------------------------------
  // Synchroniser chain
  // ---------------------------------------------------------------
  // First stage is read by the second stage only
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else begin
      stage1_r <= PIN_IN;
      stage2_r <= stage1_r;
    end
  end

  assign PIN_SYNC = stage2_r;

endmodule

// [epp_cycle_engine.sv]
// Enhanced parallel port cycle engine with APB register access
`timescale 1ns/1ps

// What this block does
// - 1.9 cycles stall host until handshake completes
// - 1.9 wait high: hold outputs until low
// - Wait low at strobe: finish when high
// - 1.9 write drives byte, write line, strobe
// - Wait released: drop strobe, peripheral latches
// - Write end latches byte, then ready
// - Peripheral drops wait before next cycle
// - 1.9 read floats bus, write line high
// - Wait high on read: capture, drop strobe
// - Read ends with ready and captured byte
// - Idle port follows control register bits
// - 1.7 watchdog aborts beyond 10 us
// - 1.7 write line follows direction bit
// - 1.7 stretches host while wait low
// - 1.7 write end: ready, strobe off, latch
// - 1.7 read: wait high ends cycle
// - Interrupt passes through uninverted
// - Strobe bit and, in 1.9, direction bit override write line
// - Active-low peripheral reset output
// - 1.9 watchdog from start to wait release
// - Timeout flag clear by write or read
module epp_cycle_engine
  import epp_cycle_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RESETN,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Port data bus
  input  wire logic [7:0]        PORT_DATA_BUS_IN,
  output logic      [7:0]        PORT_DATA_BUS_OUT,
  output logic                   PORT_DATA_BUS_OE,
  // Handshake and control outputs
  output logic                   DATA_STROBE_N,
  output logic                   ADDRESS_STROBE_OUT_N,
  output logic                   WRITE_LINE_N,
  output logic                   PERIPHERAL_RESET_N,
  output logic                   PERIPHERAL_INTERRUPT_OUT,
  // Peripheral inputs
  input  wire logic              PERIPHERAL_WAIT_N,
  input  wire logic              PERIPHERAL_INTERRUPT,
  input  wire logic              ERROR_N,
  input  wire logic              SELECT,
  input  wire logic              PAPER_END,
  input  wire logic              ACK_N,
  input  wire logic              BUSY
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (ADDR_W < 8) begin : g_bad_addr
    $error("epp_cycle_engine needs ADDR_W of at least 8");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [14:0]         pin_sync;
  logic [7:0]          pd_s;
  logic                wait_s;
  logic                irq_s;
  logic [4:0]          stat_s;
  logic [5:0]          idx;
  logic                access;
  logic                setup;
  logic                mapped;
  logic                epp_reg;
  logic                wr_done;
  logic                rd_done;
  logic                epp_en;
  logic                v17;
  logic                tsel;
  logic                control_direction_bit;
  logic                wd_expired;
  logic                drive;
  logic                write_n;
  epp_state_type       state_r,    state_nxt;
  logic                cyc_wr_r,   cyc_wr_nxt;
  logic                cyc_addr_r, cyc_addr_nxt;
  logic [WD_W-1:0]     wd_cnt_r,   wd_cnt_nxt;
  logic [7:0]          prdata_r,   prdata_nxt;
  logic [5:0]          ctrl_r,     ctrl_nxt;
  logic [7:0]          mode_r,     mode_nxt;
  logic [7:0]          pd_out_r,   pd_out_nxt;
  logic                tmo_r,      tmo_nxt;
  logic                tmo_set;
  logic                tmo_clr;
  // Clock and reset of the checks below
  default clocking cb_chk @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  epp_pin_sync #(
    .WIDTH (15)
  ) u_sync (
    .SYS_CLK  (SYS_CLK),
    .RESETN   (RESETN),
    .PIN_IN   ({PERIPHERAL_WAIT_N, PERIPHERAL_INTERRUPT, BUSY, ACK_N,
                PAPER_END, SELECT, ERROR_N, PORT_DATA_BUS_IN}),
    .PIN_SYNC (pin_sync)
  );

  assign pd_s   = pin_sync[7:0];
  assign stat_s = pin_sync[12:8];
  assign irq_s  = pin_sync[13];
  assign wait_s = pin_sync[14];

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // EPP address or data port index
  function automatic logic is_epp_idx(input logic [5:0] i);
    return (i >= IDX_EPP_ADDR) && (i <= IDX_EPP_DATA3);
  endfunction

  // Read value of a plain register
  function automatic logic [7:0] reg_read(input logic [5:0] i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      IDX_DATA:    v = pd_s;
      IDX_STATUS:  v = {~stat_s[4], stat_s[3], stat_s[2], stat_s[1], stat_s[0], 2'b00, tmo_r};
      IDX_CONTROL: v = {2'b00, ctrl_r};
      IDX_MODE:    v = mode_r;
      default:     v = 8'h00;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Mode bits and bus phases
  assign epp_en     = mode_r[MODE_EPP_EN_BIT];
  assign v17        = mode_r[MODE_V17_BIT];
  assign tsel       = mode_r[MODE_TSEL_BIT];
  assign control_direction_bit        = ctrl_r[CTL_DIR_BIT];
  assign idx        = PADDR[7:2];
  assign access     = PSEL && PENABLE;
  assign setup      = PSEL && !PENABLE;
  assign mapped     = (idx <= IDX_MODE);
  assign epp_reg    = epp_en && is_epp_idx(idx);
  assign wd_expired = (wd_cnt_r >= WD_W'(WD_CYCLES));

  // Host access to an enabled EPP port register stalls until the port cycle is done
  assign PREADY  = access && (!epp_reg || (state_r == ST_DONE));
  assign PSLVERR = access && !mapped;
  assign wr_done = PREADY && PWRITE;
  assign rd_done = PREADY && !PWRITE;
  assign PRDATA  = {24'h000000, prdata_r};

  // ---------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------
  // Next state, watchdog and read capture
  always_comb begin
    state_nxt    = state_r;
    cyc_wr_nxt   = cyc_wr_r;
    cyc_addr_nxt = cyc_addr_r;
    wd_cnt_nxt   = wd_cnt_r;
    prdata_nxt   = prdata_r;
    tmo_set      = 1'b0;
    if (setup && !(epp_en && is_epp_idx(idx))) begin
      prdata_nxt = reg_read(idx);
    end
    case (state_r)
      ST_IDLE: begin
        if (access && epp_reg) begin
          cyc_wr_nxt   = PWRITE;
          cyc_addr_nxt = (idx == IDX_EPP_ADDR);
          wd_cnt_nxt   = '0;
          state_nxt    = v17 ? ST_SETUP : ST_PRE_WAIT;
        end
      end
      ST_PRE_WAIT: begin
        if (!wait_s) begin
          state_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        state_nxt = ST_STROBE;
      end
      ST_STROBE: begin
        if (wait_s) begin
          state_nxt  = ST_DONE;
          prdata_nxt = cyc_wr_r ? prdata_r : pd_s;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Watchdog over the whole port cycle
    if ((state_r != ST_IDLE) && (state_r != ST_DONE)) begin
      wd_cnt_nxt = wd_expired ? wd_cnt_r : wd_cnt_r + WD_W'(1);
      if (wd_expired) begin
        state_nxt  = ST_DONE;
        tmo_set    = 1'b1;
        prdata_nxt = pd_s;
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r    <= ST_IDLE;
      cyc_wr_r   <= 1'b0;
      cyc_addr_r <= 1'b0;
      wd_cnt_r   <= '0;
      prdata_r   <= BYTE_RESET;
    end else begin
      state_r    <= state_nxt;
      cyc_wr_r   <= cyc_wr_nxt;
      cyc_addr_r <= cyc_addr_nxt;
      wd_cnt_r   <= wd_cnt_nxt;
      prdata_r   <= prdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  // Control, mode, output byte and timeout flag
  always_comb begin
    ctrl_nxt   = ctrl_r;
    mode_nxt   = mode_r;
    pd_out_nxt = pd_out_r;
    if (wr_done && (idx == IDX_CONTROL)) begin
      ctrl_nxt = PWDATA[5:0];
    end
    if (wr_done && (idx == IDX_MODE)) begin
      mode_nxt = PWDATA[7:0] & MODE_MASK;
    end
    if (wr_done && (idx == IDX_DATA)) begin
      pd_out_nxt = PWDATA[7:0];
    end
    // Written byte is latched at the end of setup, so it is on the bus from the strobe on
    if ((state_r == ST_SETUP) && cyc_wr_r) begin
      pd_out_nxt = PWDATA[7:0];
    end
    // Set wins over a clear in the same cycle
    tmo_clr = (wr_done && (idx == IDX_STATUS) && PWDATA[ST_TIMEOUT_BIT] && !tsel)
           || (rd_done && (idx == IDX_STATUS) && tsel);
    tmo_nxt = tmo_set || (tmo_r && !tmo_clr);
  end

  // Register storage
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r   <= CTL_RESET;
      mode_r   <= MODE_RESET;
      pd_out_r <= BYTE_RESET;
      tmo_r    <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      mode_r   <= mode_nxt;
      pd_out_r <= pd_out_nxt;
      tmo_r    <= tmo_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Port outputs
  // ---------------------------------------------------------------
  // Enhanced outputs own the port from setup through done
  assign drive = (state_r == ST_SETUP) || (state_r == ST_STROBE) || (state_r == ST_DONE);

  // Write line: 1.7 follows direction bit, strobe bit forces write
  assign write_n = (v17 ? control_direction_bit : !(cyc_wr_r && !control_direction_bit)) && !ctrl_r[CTL_STROBE_BIT];

  // Idle port follows the control register
  assign WRITE_LINE_N         = drive ? write_n : !ctrl_r[CTL_STROBE_BIT];
  assign DATA_STROBE_N        = (state_r == ST_STROBE) ? cyc_addr_r
                              : (drive ? 1'b1 : !ctrl_r[CTL_AUTOFD_BIT]);
  assign ADDRESS_STROBE_OUT_N = (state_r == ST_STROBE) ? !cyc_addr_r
                              : (drive ? 1'b1 : !ctrl_r[CTL_SELIN_BIT]);
  assign PORT_DATA_BUS_OE     = drive ? !write_n : !control_direction_bit;
  assign PORT_DATA_BUS_OUT    = pd_out_r;
  assign PERIPHERAL_RESET_N   = ctrl_r[CTL_NINIT_BIT];
  assign PERIPHERAL_INTERRUPT_OUT = irq_s;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_stall;
    (state_r == ST_STROBE) |-> !PREADY;
  endproperty
  a_stall: assert property (p_stall) else $error("host released during strobe");
  property p_prewait_hold;
    (state_r == ST_PRE_WAIT) && wait_s && !wd_expired |=> (state_r == ST_PRE_WAIT)
      && $stable(WRITE_LINE_N) && $stable(DATA_STROBE_N) && $stable(ADDRESS_STROBE_OUT_N);
  endproperty
  a_prewait_hold: assert property (p_prewait_hold) else $error("outputs moved in pre-wait");
  property p_complete;
    (state_r == ST_STROBE) && wait_s |=> (state_r == ST_DONE) ##0 (PREADY || !access);
  endproperty
  a_complete: assert property (p_complete) else $error("cycle not completed on wait high");
  property p_write_drive;
    (state_r == ST_STROBE) && cyc_wr_r && !control_direction_bit && !v17 |->
      PORT_DATA_BUS_OE && !WRITE_LINE_N && (DATA_STROBE_N != ADDRESS_STROBE_OUT_N);
  endproperty
  a_write_drive: assert property (p_write_drive) else $error("write cycle not driven");
  property p_strobe_end;
    (state_r == ST_STROBE) && wait_s |=> DATA_STROBE_N && ADDRESS_STROBE_OUT_N;
  endproperty
  a_strobe_end: assert property (p_strobe_end) else $error("strobe held after wait high");
  property p_write_latch;
    (state_r == ST_SETUP) && cyc_wr_r |=> (PORT_DATA_BUS_OUT == $past(PWDATA[7:0]));
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("written byte not latched");
  property p_read_float;
    (state_r == ST_STROBE) && !cyc_wr_r && !ctrl_r[CTL_STROBE_BIT] && !v17 |->
      !PORT_DATA_BUS_OE && WRITE_LINE_N;
  endproperty
  a_read_float: assert property (p_read_float) else $error("read cycle drives bus");
  property p_read_capture;
    (state_r == ST_STROBE) && wait_s && !cyc_wr_r && !wd_expired |=>
      (PRDATA[7:0] == $past(pd_s)) && (state_r == ST_DONE);
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read byte not returned");
  property p_watchdog;
    (state_r != ST_IDLE) && (state_r != ST_DONE) && wd_expired |=>
      tmo_r && (state_r == ST_DONE) ##1 (state_r == ST_IDLE);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog did not abort");
  property p_wd_bound;
    wd_cnt_r <= WD_W'(WD_CYCLES);
  endproperty
  a_wd_bound: assert property (p_wd_bound) else $error("cycle ran past watchdog");
  property p_tmo_clear;
    tmo_clr && !tmo_set |=> !tmo_r;
  endproperty
  a_tmo_clear: assert property (p_tmo_clear) else $error("timeout flag not cleared");
  property p_irq_pass;
    $past(RESETN, 2) |-> (PERIPHERAL_INTERRUPT_OUT == $past(PERIPHERAL_INTERRUPT, 2));
  endproperty
  a_irq_pass: assert property (p_irq_pass) else $error("interrupt not passed through");

endmodule

// [epp_peripheral_model.sv]
// Behavioural model of the external enhanced parallel port peripheral
`timescale 1ns/1ps
module epp_peripheral_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Lines from the port
  input  wire logic       data_strobe_n,
  input  wire logic       address_strobe_n,
  input  wire logic       write_line_n,
  input  wire logic [7:0] bus_level,
  // Test controls
  input  wire logic [7:0] delay,
  input  wire logic       hang,
  input  wire logic       hold_high,
  input  wire logic [7:0] read_byte,
  // Lines back to the port
  output logic            peripheral_wait_n,
  output logic            drive_oe,
  output logic [7:0]      drive_data,
  output logic [7:0]      latched_byte
);
  logic       wait_r;
  logic [7:0] cnt;
  wire        strobe_on = !data_strobe_n || !address_strobe_n;

  // Wait is low when ready, high once a transfer is done
  assign peripheral_wait_n = wait_r | hold_high;
  assign drive_data        = read_byte;

  // Release wait after the setup delay, reassert it once the strobe drops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_r       <= 1'b0;
      cnt          <= 8'h00;
      drive_oe     <= 1'b0;
      latched_byte <= 8'h00;
    end else if (strobe_on) begin
      drive_oe <= write_line_n;
      if (!hang && cnt >= delay) begin
        if (!wait_r && !write_line_n) begin
          latched_byte <= bus_level;
        end
        wait_r <= 1'b1;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end else begin
      cnt      <= 8'h00;
      wait_r   <= 1'b0;
      drive_oe <= 1'b0;
    end
  end
endmodule

// [testbench.sv]
// Self-checking testbench of the enhanced parallel port cycle engine
`timescale 1ns/1ps
module testbench;
  import epp_cycle_pkg::*;
  localparam logic [31:0] STAT = 32'h28; // Status pins as driven below
  logic        SYS_CLK = 1'b0, RESETN = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic        PREADY, PSLVERR, PORT_DATA_BUS_OE, DATA_STROBE_N, ADDRESS_STROBE_OUT_N;
  logic [7:0]  PORT_DATA_BUS_OUT, p_data, latched, last_bus = 8'h00, delay = 8'h03;
  logic        WRITE_LINE_N, PERIPHERAL_RESET_N, PERIPHERAL_INTERRUPT_OUT, wait_n, p_oe;
  logic        PERIPHERAL_INTERRUPT = 1'b0, hang = 1'b0, hold_high = 1'b0;
  logic [7:0]  rbyte = 8'h00;
  logic [31:0] rdv;
  logic        erv, exp_wr = 1'b0, in_cyc = 1'b0, saw_addr = 1'b0;
  int          wv, num_errors = 0, compares = 0, cyc = 0;
  wire  [7:0]  port_bus = PORT_DATA_BUS_OE ? PORT_DATA_BUS_OUT : (p_oe ? p_data : ~last_bus);

  // Clock and released-bus pattern
  initial forever #50 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) last_bus <= port_bus;

  epp_cycle_engine dut_u (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PORT_DATA_BUS_IN(port_bus), .PORT_DATA_BUS_OUT(PORT_DATA_BUS_OUT),
    .PORT_DATA_BUS_OE(PORT_DATA_BUS_OE), .DATA_STROBE_N(DATA_STROBE_N),
    .ADDRESS_STROBE_OUT_N(ADDRESS_STROBE_OUT_N), .WRITE_LINE_N(WRITE_LINE_N),
    .PERIPHERAL_RESET_N(PERIPHERAL_RESET_N), .PERIPHERAL_INTERRUPT_OUT(PERIPHERAL_INTERRUPT_OUT),
    .PERIPHERAL_WAIT_N(wait_n), .PERIPHERAL_INTERRUPT(PERIPHERAL_INTERRUPT), .ERROR_N(1'b1),
    .SELECT(1'b0), .PAPER_END(1'b1), .ACK_N(1'b0), .BUSY(1'b1));

  epp_peripheral_model peer_u (.clk(SYS_CLK), .rst_n(RESETN), .data_strobe_n(DATA_STROBE_N),
    .address_strobe_n(ADDRESS_STROBE_OUT_N), .write_line_n(WRITE_LINE_N), .bus_level(port_bus),
    .delay(delay), .hang(hang), .hold_high(hold_high), .read_byte(rbyte),
    .peripheral_wait_n(wait_n), .drive_oe(p_oe), .drive_data(p_data), .latched_byte(latched));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // APB transfer, waits for PREADY
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge SYS_CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= {idx, 2'b00};
    PWDATA <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    wv = 0;
    do begin
      @(posedge SYS_CLK);
      wv++;
    end while (PREADY !== 1'b1);
    rdv = PRDATA;
    erv = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Port cycle, with the expected write line level watched meanwhile
  task automatic epp(input logic w, input logic [5:0] idx, input logic [31:0] wd,
                     input logic line);
    exp_wr = line;
    in_cyc = 1'b1;
    apb(w, idx, wd);
    in_cyc = 1'b0;
  endtask

  // Strobe-time monitor and hang limit
  always @(posedge SYS_CLK) begin
    if (in_cyc && !(DATA_STROBE_N && ADDRESS_STROBE_OUT_N)) begin
      chk1(WRITE_LINE_N, !exp_wr);
      chk1(PORT_DATA_BUS_OE, exp_wr);
      if (!ADDRESS_STROBE_OUT_N) saw_addr = 1'b1;
    end
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_idle();
    chk1(PERIPHERAL_RESET_N, 1'b0);
    chk1(WRITE_LINE_N, 1'b1);
    apb(1'b1, IDX_CONTROL, 32'h0B);
    @(posedge SYS_CLK);
    chk({29'h0, WRITE_LINE_N, DATA_STROBE_N, ADDRESS_STROBE_OUT_N}, 32'h0);
    chk1(PERIPHERAL_RESET_N, 1'b0);
    apb(1'b1, IDX_CONTROL, 32'h24);
    @(posedge SYS_CLK);
    chk1(PORT_DATA_BUS_OE, 1'b0);
    chk1(PERIPHERAL_RESET_N, 1'b1);
    apb(1'b0, 6'h09, 32'h0);
    chk1(erv, 1'b1);
    apb(1'b0, IDX_EPP_DATA0, 32'h0);
    chk(wv, 32'h1);
  endtask

  task automatic t_v19();
    apb(1'b1, IDX_MODE, 32'h01);
    apb(1'b1, IDX_CONTROL, 32'h04);
    epp(1'b1, IDX_EPP_DATA0, 32'hA5, 1'b1);
    chk1(wv > 3, 1'b1);
    chk({24'h0, latched}, 32'hA5);
    epp(1'b1, IDX_EPP_ADDR, 32'h3C, 1'b1);
    chk1(saw_addr, 1'b1);
    chk({24'h0, latched}, 32'h3C);
    rbyte = 8'h5A;
    epp(1'b0, IDX_EPP_DATA3, 32'h0, 1'b0);
    chk(rdv, 32'h5A);
    rbyte = 8'hC3;
    epp(1'b0, IDX_EPP_ADDR, 32'h0, 1'b0);
    chk(rdv, 32'hC3);
  endtask

  task automatic t_hold();
    hold_high = 1'b1;
    fork
      epp(1'b1, IDX_EPP_DATA0, 32'h96, 1'b1);
      begin
        repeat (20) @(posedge SYS_CLK);
        chk1(DATA_STROBE_N, 1'b1);
        chk1(WRITE_LINE_N, 1'b1);
        hold_high <= 1'b0;
      end
    join
    chk({24'h0, latched}, 32'h96);
  endtask

  task automatic t_tmo19();
    hang = 1'b1;
    epp(1'b1, IDX_EPP_DATA0, 32'h11, 1'b1);
    hang = 1'b0;
    chk1(wv >= 100, 1'b1);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk(rdv, STAT | 32'h1);
    apb(1'b1, IDX_STATUS, 32'h0);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk(rdv, STAT | 32'h1);
    apb(1'b1, IDX_STATUS, 32'h1);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk(rdv, STAT);
  endtask

  task automatic t_v17();
    apb(1'b1, IDX_MODE, 32'h13);
    delay = 8'h05;
    epp(1'b1, IDX_EPP_DATA0 + 6'h1, 32'h66, 1'b1);
    chk1(wv > 5, 1'b1);
    chk({24'h0, latched}, 32'h66);
    apb(1'b1, IDX_CONTROL, 32'h24);
    rbyte = 8'h99;
    epp(1'b0, IDX_EPP_DATA0 + 6'h2, 32'h0, 1'b0);
    chk(rdv, 32'h99);
    hang = 1'b1;
    epp(1'b0, IDX_EPP_DATA0, 32'h0, 1'b0);
    hang = 1'b0;
    chk1(wv >= 100, 1'b1);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk(rdv, STAT | 32'h1);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk(rdv, STAT);
  endtask

  task automatic t_misc();
    apb(1'b1, IDX_MODE, 32'h01);
    apb(1'b1, IDX_CONTROL, 32'h05);
    epp(1'b0, IDX_EPP_DATA0, 32'h0, 1'b1);
    PERIPHERAL_INTERRUPT <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    chk1(PERIPHERAL_INTERRUPT_OUT, 1'b1);
    PERIPHERAL_INTERRUPT <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    chk1(PERIPHERAL_INTERRUPT_OUT, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    t_idle();
    t_v19();
    t_hold();
    t_tmo19();
    t_v17();
    t_misc();
    test_done();
  end
endmodule
